// ==== src/pms_pkg.sv ====
package pms_pkg;

  // Power modes, highest to lowest consumption
  typedef enum logic [3:0] {
    PMS_ACTIVE = 4'b0001,
    PMS_IDLE   = 4'b0010,
    PMS_SLEEP  = 4'b0100,
    PMS_DEEP   = 4'b1000
  } pms_mode_type;

  // Register indices (word aligned byte addresses)
  localparam logic [7:0] PMS_ADDR_CTRL      = 8'h00;
  localparam logic [7:0] PMS_ADDR_IDLE_TO   = 8'h04;
  localparam logic [7:0] PMS_ADDR_SLEEP_TO  = 8'h08;
  localparam logic [7:0] PMS_ADDR_DEEP_TO   = 8'h0C;
  localparam logic [7:0] PMS_ADDR_STATUS    = 8'h10;
  localparam logic [7:0] PMS_ADDR_RF_FORCE  = 8'h14;
  localparam logic [7:0] PMS_ADDR_LPO_WAKE  = 8'h18;

  // Control register fields
  localparam int unsigned PMS_CTRL_AUTO_BIT  = 0;
  localparam int unsigned PMS_CTRL_SWDN_BIT  = 1;
  localparam int unsigned PMS_CTRL_SWWK_BIT  = 2;
  localparam int unsigned PMS_CTRL_LPC_BIT   = 3;
  localparam int unsigned PMS_CTRL_REGEN_BIT = 4;

  // Reset values
  localparam logic [4:0]  PMS_CTRL_RST     = 5'h11;
  localparam logic [23:0] PMS_IDLE_TO_RST  = 24'h009C40;
  localparam logic [23:0] PMS_SLEEP_TO_RST = 24'h09C400;
  localparam logic [23:0] PMS_DEEP_TO_RST  = 24'hFFFFFF;
  localparam logic [3:0]  PMS_RF_FORCE_RST = 4'h0;
  localparam logic [15:0] PMS_LPO_WAKE_RST = 16'h0040;

  // Timing: inactivity timer tick of 1 us derived from the 40 MHz clock
  localparam int unsigned PMS_CLK_MHZ     = 40;
  localparam int unsigned PMS_TICK_NS     = 1000;
  localparam int unsigned PMS_TICK_CYCLES = PMS_TICK_NS * PMS_CLK_MHZ / 1000;
  localparam logic [5:0]  PMS_TICK_LAST   = 6'(PMS_TICK_CYCLES - 1);

  // Radio power-down bundle: one bit per transceiver section
  typedef struct packed {
    logic pa;
    logic pll;
    logic rx;
    logic tx;
  } pms_rf_pd_type;

endpackage

// ==== src/pms_edge.sv ====
`timescale 1ns/100ps
// Rising-edge detector for the low-power oscillator input
module pms_edge (
  input  wire logic i_sys_clk,  // System clock
  input  wire logic i_arst_n,   // Async reset, active low
  input  wire logic i_level,    // Sampled level
  output logic      o_rise      // One-cycle pulse on rise
);

  logic level_q;

  // Previous level
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      level_q <= 1'b0;
    end else begin
      level_q <= i_level;
    end
  end

  assign o_rise = i_level & ~level_q;

endmodule

// ==== src/pms_sequencer.sv ====
`timescale 1ns/100ps
module pms_sequencer
  import pms_pkg::*;
(
  input  wire logic          i_sys_clk,       // System clock 40 MHz
  input  wire logic          i_arst_n,        // Async reset, active low
  input  wire logic [7:0]    i_addr,          // Register byte address
  input  wire logic [31:0]   i_wdata,         // Write data
  input  wire logic          i_wr,            // Write strobe
  input  wire logic          i_rd,            // Read strobe
  output logic [31:0]        o_rdata,         // Read data, cycle after read
  input  wire logic          i_user_act,      // User activity event
  input  wire logic          i_io_wake,       // User event seen by I/O domain
  input  wire pms_pkg::pms_rf_pd_type i_pkt_rf_on, // Packet handler RF section enables
  input  wire logic          i_pkt_pm_down,   // Packet handler step-down request
  input  wire logic          i_lpo_clk,       // Low-power oscillator, sampled
  output pms_pkg::pms_mode_type o_mode,       // Current power mode
  output pms_pkg::pms_rf_pd_type o_rf_pd,     // Radio power-down controls
  output logic               o_core_sup_en,   // Core supply output enable
  output logic               o_amp_sup_en,    // Amplifier supply enable
  output logic               o_reg_en,        // On-chip regulator enable
  output logic               o_io_sup_en,     // I/O supply domain enable
  output logic               o_lpo_sel,       // Run from low-power oscillator
  output logic               o_lpc_wake       // Low-power connection wake pulse
);

  pms_mode_type  mode_q;
  pms_mode_type  mode_d;
  logic [4:0]    ctrl_q;
  logic [23:0]   idle_to_q;
  logic [23:0]   sleep_to_q;
  logic [23:0]   deep_to_q;
  logic [3:0]    rf_force_q;
  logic [15:0]   lpo_wake_q;
  logic [23:0]   timer_q;
  logic [5:0]    tick_cnt_q;
  logic          tick;
  logic [15:0]   lpo_cnt_q;
  logic          lpo_rise;
  logic          wr_ctrl;
  logic          sw_down;
  logic          sw_wake;
  logic          wake_ev;
  logic          step_down;
  logic          mode_chg;
  logic [23:0]   load_val;
  logic [31:0]   rdata_d;
  pms_rf_pd_type rf_pd_d;
  logic [3:0]    rf_on_v;
  logic [3:0]    rf_pd_v;
  logic          deep_next;

  // Register write decode, pulse bits of control
  assign wr_ctrl = i_wr & (i_addr == PMS_ADDR_CTRL);
  assign sw_down = wr_ctrl & i_wdata[PMS_CTRL_SWDN_BIT];
  assign sw_wake = wr_ctrl & i_wdata[PMS_CTRL_SWWK_BIT];

  // Control register, pulse bits are never stored
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= PMS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q[PMS_CTRL_AUTO_BIT]  <= i_wdata[PMS_CTRL_AUTO_BIT];
      ctrl_q[PMS_CTRL_LPC_BIT]   <= i_wdata[PMS_CTRL_LPC_BIT];
      ctrl_q[PMS_CTRL_REGEN_BIT] <= i_wdata[PMS_CTRL_REGEN_BIT];
    end
  end

  // Active to Idle timeout
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idle_to_q <= PMS_IDLE_TO_RST;
    end else if (i_wr && (i_addr == PMS_ADDR_IDLE_TO)) begin
      idle_to_q <= i_wdata[23:0];
    end
  end

  // Idle to Sleep timeout
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sleep_to_q <= PMS_SLEEP_TO_RST;
    end else if (i_wr && (i_addr == PMS_ADDR_SLEEP_TO)) begin
      sleep_to_q <= i_wdata[23:0];
    end
  end

  // Sleep to deep power-off timeout
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      deep_to_q <= PMS_DEEP_TO_RST;
    end else if (i_wr && (i_addr == PMS_ADDR_DEEP_TO)) begin
      deep_to_q <= i_wdata[23:0];
    end
  end

  // Per-section radio force-down
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rf_force_q <= PMS_RF_FORCE_RST;
    end else if (i_wr && (i_addr == PMS_ADDR_RF_FORCE)) begin
      rf_force_q <= i_wdata[3:0];
    end
  end

  // Low-power connection wake period
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lpo_wake_q <= PMS_LPO_WAKE_RST;
    end else if (i_wr && (i_addr == PMS_ADDR_LPO_WAKE)) begin
      lpo_wake_q <= i_wdata[15:0];
    end
  end

  // Microsecond tick divider
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_cnt_q <= 6'h00;
    end else if (tick) begin
      tick_cnt_q <= 6'h00;
    end else begin
      tick_cnt_q <= tick_cnt_q + 6'h01;
    end
  end
  assign tick = (tick_cnt_q == PMS_TICK_LAST);

  // Wake and step-down conditions
  assign wake_ev   = i_user_act | sw_wake | ((mode_q == PMS_DEEP) & i_io_wake);
  assign step_down = ctrl_q[PMS_CTRL_AUTO_BIT] & tick & (timer_q == 24'h000000)
                     | sw_down | i_pkt_pm_down;

  // Mode transitions
  always_comb begin
    mode_d = mode_q;
    if (wake_ev) begin
      mode_d = PMS_ACTIVE;
    end else if (step_down) begin
      case (mode_q)
        PMS_ACTIVE: mode_d = PMS_IDLE;
        PMS_IDLE:   mode_d = PMS_SLEEP;
        PMS_SLEEP:  mode_d = PMS_DEEP;
        PMS_DEEP:   mode_d = PMS_DEEP;
        default:    mode_d = PMS_ACTIVE;
      endcase
    end
  end
  assign mode_chg = (mode_d != mode_q);

  // Mode register
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_q <= PMS_ACTIVE;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Timeout of the mode being entered
  always_comb begin
    case (mode_d)
      PMS_ACTIVE: load_val = idle_to_q;
      PMS_IDLE:   load_val = sleep_to_q;
      PMS_SLEEP:  load_val = deep_to_q;
      PMS_DEEP:   load_val = 24'h000000;
      default:    load_val = idle_to_q;
    endcase
  end

  // Inactivity timer, restarted by activity or mode entry
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      timer_q <= PMS_IDLE_TO_RST;
    end else if (mode_chg || i_user_act) begin
      timer_q <= load_val;
    end else if (tick && timer_q != 24'h000000) begin
      timer_q <= timer_q - 24'h000001;
    end
  end

  // Low-power oscillator edges
  pms_edge u_lpo_edge (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_level   (i_lpo_clk),
    .o_rise    (lpo_rise)
  );

  // Low-power connection wake counter on oscillator edges
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lpo_cnt_q  <= 16'h0000;
      o_lpc_wake <= 1'b0;
    end else if (!ctrl_q[PMS_CTRL_LPC_BIT]) begin
      lpo_cnt_q  <= 16'h0000;
      o_lpc_wake <= 1'b0;
    end else if (lpo_rise && lpo_cnt_q >= lpo_wake_q - 16'h0001) begin
      lpo_cnt_q  <= 16'h0000;
      o_lpc_wake <= 1'b1;
    end else begin
      lpo_cnt_q  <= lpo_rise ? lpo_cnt_q + 16'h0001 : lpo_cnt_q;
      o_lpc_wake <= 1'b0;
    end
  end

  // RF power-down: packet handler enables unless forced down or deep off
  assign rf_on_v   = i_pkt_rf_on;
  assign deep_next = (mode_d == PMS_DEEP);
  for (genvar g = 0; g < 4; g++) begin : g_rf_pd
    assign rf_pd_v[g] = ~rf_on_v[g] | rf_force_q[g] | deep_next;
  end
  assign rf_pd_d = rf_pd_v;

  // Mode output, mirrors the mode register
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mode <= PMS_ACTIVE;
    end else begin
      o_mode <= mode_d;
    end
  end

  // Radio power-down controls
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rf_pd <= 4'hF;
    end else begin
      o_rf_pd <= rf_pd_d;
    end
  end

  // Core and amplifier supplies, cut in deep power-off
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_core_sup_en <= 1'b1;
      o_amp_sup_en  <= 1'b1;
    end else begin
      o_core_sup_en <= (mode_d != PMS_DEEP);
      o_amp_sup_en  <= (mode_d != PMS_DEEP);
    end
  end

  // Regulator, cut in deep power-off when enabled to
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_en <= 1'b1;
    end else begin
      o_reg_en <= (mode_d != PMS_DEEP) | ~ctrl_q[PMS_CTRL_REGEN_BIT];
    end
  end

  // I/O domain stays up to watch for user events
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_io_sup_en <= 1'b1;
    end else begin
      o_io_sup_en <= 1'b1;
    end
  end

  // Low-power oscillator selection
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_lpo_sel <= 1'b0;
    end else begin
      o_lpo_sel <= ctrl_q[PMS_CTRL_LPC_BIT] | (mode_d == PMS_SLEEP);
    end
  end

  // Read mux
  always_comb begin
    rdata_d = 32'h00000000;
    case (i_addr)
      PMS_ADDR_CTRL:     rdata_d = {27'h0, ctrl_q};
      PMS_ADDR_IDLE_TO:  rdata_d = {8'h00, idle_to_q};
      PMS_ADDR_SLEEP_TO: rdata_d = {8'h00, sleep_to_q};
      PMS_ADDR_DEEP_TO:  rdata_d = {8'h00, deep_to_q};
      PMS_ADDR_STATUS:   rdata_d = {4'h0, mode_q, timer_q};
      PMS_ADDR_RF_FORCE: rdata_d = {28'h0000000, rf_force_q};
      PMS_ADDR_LPO_WAKE: rdata_d = {16'h0000, lpo_wake_q};
      default:           rdata_d = 32'h00000000;
    endcase
  end

  // Read data register, valid only the cycle after a read
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

endmodule

// ==== sim/pms_checker.sv ====
`timescale 1ns/100ps
// Watches mode, supply, radio and read-data outputs
module pms_checker (
  input wire logic                   i_sys_clk,     // Clock
  input wire logic                   i_arst_n,      // Reset
  input wire logic                   i_rd,          // Read strobe
  input wire logic [31:0]            o_rdata,       // Read data
  input wire logic                   i_user_act,    // Activity
  input wire logic                   i_io_wake,     // IO event
  input wire pms_pkg::pms_rf_pd_type i_pkt_rf_on,   // Section enables
  input wire pms_pkg::pms_mode_type  o_mode,        // Mode
  input wire pms_pkg::pms_rf_pd_type o_rf_pd,       // Section downs
  input wire logic                   o_core_sup_en, // Core supply
  input wire logic                   o_amp_sup_en,  // Amp supply
  input wire logic                   o_reg_en,      // Regulator
  input wire logic                   o_io_sup_en,   // IO domain
  input wire logic                   o_lpo_sel,     // Slow clock select
  input wire logic                   o_lpc_wake     // Wake pulse
);
  import pms_pkg::*;
  // One clock, quiet in reset
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  one_hot_a: assert property ($onehot(o_mode)) else $error("mode not one-hot");
  step_one_a: assert property ($changed(o_mode) && o_mode != PMS_ACTIVE |-> o_mode == ($past(o_mode) << 1))
    else $error("mode skipped a step");
  wake_act_a: assert property (i_user_act |=> o_mode == PMS_ACTIVE) else $error("no wake on activity");
  deep_cut_a: assert property (o_mode == PMS_DEEP ##1 o_mode == PMS_DEEP |->
    !o_core_sup_en && !o_amp_sup_en && o_rf_pd == 4'hF) else $error("power left on in deep mode");
  io_wake_a: assert property (o_mode == PMS_DEEP && i_io_wake |=> o_mode == PMS_ACTIVE) else $error("no io wake");
  io_on_a: assert property (o_io_sup_en) else $error("io domain dropped");
  powered_a: assert property (o_mode == PMS_ACTIVE ##1 o_mode == PMS_ACTIVE |->
    o_core_sup_en && o_amp_sup_en && o_reg_en) else $error("supply off while active");
  rf_follow_a: assert property (1'b1 |=> (o_rf_pd | $past(i_pkt_rf_on)) == 4'hF) else $error("section not down");
  sleep_lpo_a: assert property (o_mode == PMS_SLEEP ##1 o_mode == PMS_SLEEP |-> o_lpo_sel) else $error("no slow clock");
  wake_pulse_a: assert property (o_lpc_wake |=> !o_lpc_wake) else $error("wake pulse too long");
  rd_idle_a: assert property (!i_rd |=> o_rdata == 32'h0) else $error("read data without read");
  // Main scenarios reached
  cover property (o_mode == PMS_DEEP && i_io_wake);
  cover property (o_mode == PMS_SLEEP && i_user_act);
  cover property (o_lpc_wake);
endmodule
bind pms_sequencer pms_checker pms_checker_inst (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_user_act(i_user_act), .i_io_wake(i_io_wake), .i_pkt_rf_on(i_pkt_rf_on), .o_mode(o_mode),
  .o_rf_pd(o_rf_pd), .o_core_sup_en(o_core_sup_en), .o_amp_sup_en(o_amp_sup_en), .o_reg_en(o_reg_en),
  .o_io_sup_en(o_io_sup_en), .o_lpo_sel(o_lpo_sel), .o_lpc_wake(o_lpc_wake));

// ==== sim/pms_far_model.sv ====
`timescale 1ns/100ps
// Packet handler section enables and the low-power oscillator
module pms_far_model (
  input  wire logic              i_sys_clk,  // System clock
  input  wire logic              i_lpo_run,  // Oscillator running
  input  wire logic [3:0]        i_rf_mask,  // Sections the packet needs
  output logic                   o_lpo_clk,  // Slow oscillator
  output pms_pkg::pms_rf_pd_type o_pkt_rf_on // Section enables
);
  import pms_pkg::*;
  logic [3:0] div_q = 4'h0;
  initial o_lpo_clk = 1'b0;
  initial o_pkt_rf_on = 4'hF;
  // Half period of 16 cycles, held low when stopped
  always @(posedge i_sys_clk) begin
    div_q <= i_lpo_run ? div_q + 4'h1 : 4'h0;
    o_lpo_clk <= i_lpo_run && (o_lpo_clk ^ (div_q == 4'hF));
  end
  // Enables change only on a system clock edge
  always @(posedge i_sys_clk) o_pkt_rf_on <= i_rf_mask;
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import pms_pkg::*;
  logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, lpo_run = 1'b0;
  logic i_user_act = 1'b0, i_io_wake = 1'b0, i_pkt_pm_down = 1'b0, i_lpo_clk, o_lpc_wake;
  logic [7:0] i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [3:0] rf_mask = 4'hF;
  logic o_core_sup_en, o_amp_sup_en, o_reg_en, o_io_sup_en, o_lpo_sel;
  pms_rf_pd_type i_pkt_rf_on, o_rf_pd;
  pms_mode_type o_mode;
  int mismatches = 0, tests_run = 0, cyc, n = 0;
  logic [7:0] rst_a [7] = '{PMS_ADDR_CTRL, PMS_ADDR_IDLE_TO, PMS_ADDR_SLEEP_TO, PMS_ADDR_DEEP_TO,
                            PMS_ADDR_RF_FORCE, PMS_ADDR_LPO_WAKE, 8'h1C};
  logic [31:0] rst_v [7] = '{32'(PMS_CTRL_RST), 32'(PMS_IDLE_TO_RST), 32'(PMS_SLEEP_TO_RST),
                             32'(PMS_DEEP_TO_RST), 32'(PMS_RF_FORCE_RST), 32'(PMS_LPO_WAKE_RST), 32'h0};
  pms_sequencer pms_sequencer_inst (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_user_act(i_user_act),
    .i_io_wake(i_io_wake), .i_pkt_rf_on(i_pkt_rf_on), .i_pkt_pm_down(i_pkt_pm_down), .i_lpo_clk(i_lpo_clk),
    .o_mode(o_mode), .o_rf_pd(o_rf_pd), .o_core_sup_en(o_core_sup_en), .o_amp_sup_en(o_amp_sup_en),
    .o_reg_en(o_reg_en), .o_io_sup_en(o_io_sup_en), .o_lpo_sel(o_lpo_sel), .o_lpc_wake(o_lpc_wake));
  pms_far_model pms_far_model_inst (.i_sys_clk(i_sys_clk), .i_lpo_run(lpo_run), .i_rf_mask(rf_mask),
    .o_lpo_clk(i_lpo_clk), .o_pkt_rf_on(i_pkt_rf_on));
  // 40 MHz clock and run-length guard
  always #12.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    n++;
    if (n == 20000) begin
      mismatches++;
      close_out;
    end
  end
  task tick(input int k);
    repeat (k) @(posedge i_sys_clk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
    tick(1);
    i_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    i_addr <= a; i_rd <= 1'b1;
    tick(1);
    i_rd <= 1'b0;
    #1 chk(o_rdata & m, e);
  endtask
  // One-cycle pulse of activity, io event or step-down
  task pulse(input logic [2:0] p);
    {i_user_act, i_io_wake, i_pkt_pm_down} <= p;
    tick(1);
    {i_user_act, i_io_wake, i_pkt_pm_down} <= 3'h0;
  endtask
  // Waits for a mode, or for a wake pulse when w is set
  task wait_for(input pms_mode_type m, input logic w, input int lim);
    cyc = 0;
    do begin tick(1); #1; cyc++; end while ((w ? o_lpc_wake !== 1'b1 : o_mode !== m) && cyc < lim);
    chk(w ? 32'(o_lpc_wake) : 32'(o_mode), w ? 32'h1 : 32'(m));
  endtask
  task close_out;
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    tick(3);
    i_arst_n <= 1'b1;
    tick(1);
    for (int k = 0; k < 7; k++) rd(rst_a[k], rst_v[k], 32'hFFFFFFFF);
    rd(PMS_ADDR_STATUS, 32'h01000000, 32'hFF000000);
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h0, 32'hFFFFFFFF);
    wr(PMS_ADDR_IDLE_TO, 32'h4);
    wr(PMS_ADDR_SLEEP_TO, 32'h9);
    wr(PMS_ADDR_DEEP_TO, 32'h3);
    wr(PMS_ADDR_LPO_WAKE, 32'h3);
    // Activity more often than the timeout keeps the chip active
    repeat (4) begin pulse(3'h4); tick(120); end
    #1 chk(o_mode, PMS_ACTIVE);
    pulse(3'h4);
    wait_for(PMS_IDLE, 1'b0, 300);
    wait_for(PMS_SLEEP, 1'b0, 500);
    chk(cyc >= 350 && cyc <= 420, 32'h1);
    tick(2);
    #1 chk(o_lpo_sel, 32'h1);
    wait_for(PMS_DEEP, 1'b0, 300);
    tick(2);
    #1 chk({o_io_sup_en, o_core_sup_en, o_amp_sup_en, o_reg_en, o_rf_pd}, 32'h8F);
    pulse(3'h1);
    tick(2);
    #1 chk(o_mode, PMS_DEEP);
    pulse(3'h2);
    wait_for(PMS_ACTIVE, 1'b0, 3);
    // Manual stepping by register, packet handler and activity
    wr(PMS_ADDR_CTRL, 32'h12);
    wait_for(PMS_IDLE, 1'b0, 3);
    pulse(3'h1);
    wait_for(PMS_SLEEP, 1'b0, 3);
    pulse(3'h2);
    tick(2);
    #1 chk(o_mode, PMS_SLEEP);
    pulse(3'h4);
    wait_for(PMS_ACTIVE, 1'b0, 3);
    pulse(3'h1);
    tick(2);
    pulse(3'h1);
    wait_for(PMS_SLEEP, 1'b0, 3);
    // Regulator left on in deep power-off when its cut is disabled
    wr(PMS_ADDR_CTRL, 32'h02);
    wait_for(PMS_DEEP, 1'b0, 3);
    tick(2);
    #1 chk({o_reg_en, o_core_sup_en, o_amp_sup_en}, 32'h4);
    wr(PMS_ADDR_CTRL, 32'h14);
    wait_for(PMS_ACTIVE, 1'b0, 3);
    // Sections follow packet enables and the force register
    rf_mask <= 4'hA;
    tick(3);
    #1 chk(o_rf_pd, 32'h5);
    wr(PMS_ADDR_RF_FORCE, 32'h8);
    tick(2);
    #1 chk(o_rf_pd, 32'hD);
    // Low-power connection wakes every third oscillator rise
    wr(PMS_ADDR_CTRL, 32'h18);
    lpo_run <= 1'b1;
    tick(2);
    #1 chk(o_lpo_sel, 32'h1);
    wait_for(PMS_ACTIVE, 1'b1, 200);
    wait_for(PMS_ACTIVE, 1'b1, 150);
    chk(cyc >= 94 && cyc <= 98, 32'h1);
    close_out;
  end
endmodule
